/* verilog/uhs_regs.svh */
// register offsets, field positions, reset values and timing figures of the
// host status / interrupt enable / frame number bank; definitions only
`ifndef UHS_REGS_SVH
`define UHS_REGS_SVH

// byte offsets from the i/o base
`define UHS_OFS_EVENT_FLAGS 8'h02
`define UHS_OFS_INT_ENABLES 8'h04
`define UHS_OFS_FRAME_INDEX 8'h06

// reset values
`define UHS_RST_EVENT_FLAGS 6'h20
`define UHS_RST_INT_ENABLES 4'h0
`define UHS_RST_FRAME_INDEX 11'h000

// host_event_flags bits
`define UHS_STS_HALTED 5
`define UHS_STS_PROC_ERR 4
`define UHS_STS_SYS_ERR 3
`define UHS_STS_RESUME 2
`define UHS_STS_ERR_INT 1
`define UHS_STS_DONE_INT 0
`define UHS_STS_WIDTH 6

// interrupt_source_enables bits
`define UHS_EN_SHORT 3
`define UHS_EN_DONE 2
`define UHS_EN_RESUME 1
`define UHS_EN_TIMEOUT 0
`define UHS_EN_WIDTH 4

// frame_counter_index fields
`define UHS_FRN_WIDTH 11
`define UHS_FRN_IDX_WIDTH 10
`define UHS_BASE_LSB 12

// frame period and core clock period, in ns
`define UHS_FRAME_NS 1000000
`define UHS_CLK_NS 20

`endif

/* verilog/uhs_pkg.sv */
// types shared by the host status / frame number bank
// assumes uhs_regs.svh is compiled alongside for the numeric constants
package uhs_pkg;

  typedef enum logic [1:0] {
    UHS_STOPPED  = 2'b00,
    UHS_RUNNING  = 2'b01,
    UHS_DRAINING = 2'b10
  } uhs_sched_type;

endpackage

/* verilog/uhs_frame_timer.sv */
// frame period timer: one-cycle tick at the end of every frame
// assumes run comes from logic on core_clk; timer restarts whenever run is low
`timescale 1ns/1ps
module uhs_frame_timer #(
  parameter int FRAME_CYCLES = 50000
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic run,
  output logic tick
);

  localparam int CW = $clog2(FRAME_CYCLES);
  localparam logic [CW-1:0] LAST = CW'(FRAME_CYCLES - 1);

  logic [CW-1:0] cnt_r;

  // a stop restarts the frame so a later start begins on a fresh frame
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
    end else if (ce) begin
      if (!run || cnt_r == LAST) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick <= 1'b0;
    end else if (ce) begin
      tick <= run && cnt_r == LAST;
    end
  end

endmodule

/* verilog/uhs_status_frame.sv */
// host controller event flags, interrupt enables and frame number registers
// assumes: the register port and all event inputs come from logic on core_clk,
// except resume_pin, which arrives from the port and is synchronised here;
// the command logic drops run_stop when run_stop_clr pulses
`timescale 1ns/1ps
`include "uhs_regs.svh"

module uhs_status_frame #(
  parameter int FRAME_CYCLES = `UHS_FRAME_NS / `UHS_CLK_NS
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [1:0] io_be,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  input wire logic run_stop,
  input wire logic global_suspend,
  input wire logic xact_busy,
  input wire logic consistency_err,
  input wire logic sys_err,
  input wire logic resume_pin,
  input wire logic xact_done,
  input wire logic xact_err,
  input wire logic xact_notify,
  input wire logic short_pkt,
  input wire logic short_detect_en,
  input wire logic [31:0] frame_list_base,
  output logic irq,
  output logic run_stop_clr,
  output logic [10:0] frame_number,
  output logic [31:0] frame_list_addr
);

  uhs_pkg::uhs_sched_type state_r;
  uhs_pkg::uhs_sched_type state_nxt;
  logic [`UHS_STS_WIDTH-1:0] sts_r;
  logic [`UHS_STS_WIDTH-1:0] sts_set;
  logic [`UHS_STS_WIDTH-1:0] sts_clr;
  logic [`UHS_EN_WIDTH-1:0] en_r;
  logic done_cause_r;
  logic short_cause_r;
  logic resume_meta_r;
  logic resume_sync_r;
  logic frame_tick;
  logic halt_set;
  logic wr_sts;
  logic wr_en;
  logic wr_frn;
  logic irq_nxt;
  logic [15:0] rdata_nxt;
  logic done_notify;
  logic done_short;

  assign wr_sts = io_wr && io_addr == `UHS_OFS_EVENT_FLAGS;
  assign wr_en = io_wr && io_addr == `UHS_OFS_INT_ENABLES;
  // only full-word writes are taken, and only while run control is low
  assign wr_frn = io_wr && io_addr == `UHS_OFS_FRAME_INDEX && io_be == 2'b11 && !run_stop;

  // resume comes straight from the port, so it is synchronised first
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      resume_meta_r <= 1'b0;
      resume_sync_r <= 1'b0;
    end else if (ce) begin
      resume_meta_r <= resume_pin;
      resume_sync_r <= resume_meta_r;
    end
  end

  // schedule run / drain / stopped tracking
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      uhs_pkg::UHS_STOPPED: begin
        if (run_stop) begin
          state_nxt = uhs_pkg::UHS_RUNNING;
        end
      end
      uhs_pkg::UHS_RUNNING: begin
        if (!run_stop) begin
          state_nxt = xact_busy ? uhs_pkg::UHS_DRAINING : uhs_pkg::UHS_STOPPED;
        end
      end
      uhs_pkg::UHS_DRAINING: begin
        if (!xact_busy) begin
          state_nxt = uhs_pkg::UHS_STOPPED;
        end
      end
      default: begin
        state_nxt = uhs_pkg::UHS_STOPPED;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= uhs_pkg::UHS_STOPPED;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // any stop, whoever dropped run control, lands here once the bus is idle
  assign halt_set = state_r != uhs_pkg::UHS_STOPPED && !run_stop && !xact_busy;
  assign done_notify = xact_done && xact_notify;
  assign done_short = xact_done && short_pkt && short_detect_en;

  // only controller-level events feed the flags; bus result codes stay out
  always_comb begin
    sts_set = '0;
    sts_set[`UHS_STS_HALTED] = halt_set;
    sts_set[`UHS_STS_PROC_ERR] = consistency_err;
    sts_set[`UHS_STS_SYS_ERR] = sys_err;
    sts_set[`UHS_STS_RESUME] = resume_sync_r && global_suspend;
    sts_set[`UHS_STS_ERR_INT] = xact_done && xact_err;
    sts_set[`UHS_STS_DONE_INT] = done_notify || done_short;
  end

  assign sts_clr = (wr_sts && io_be[0]) ? io_wdata[`UHS_STS_WIDTH-1:0] : '0;

  // a set in the same cycle as its clear wins, so no event is lost
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sts_r <= `UHS_RST_EVENT_FLAGS;
    end else if (ce) begin
      sts_r <= (sts_r & ~sts_clr) | sts_set;
    end
  end

  // remember which cause raised the completion flag so each enable gates its own
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      done_cause_r <= 1'b0;
      short_cause_r <= 1'b0;
    end else if (ce) begin
      done_cause_r <= (done_cause_r && !sts_clr[`UHS_STS_DONE_INT]) || done_notify;
      short_cause_r <= (short_cause_r && !sts_clr[`UHS_STS_DONE_INT]) || done_short;
    end
  end

  // fatal errors stop the schedule through the command logic
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_stop_clr <= 1'b0;
    end else if (ce) begin
      run_stop_clr <= consistency_err || sys_err;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      en_r <= `UHS_RST_INT_ENABLES;
    end else if (ce && wr_en && io_be[0]) begin
      en_r <= io_wdata[`UHS_EN_WIDTH-1:0];
    end
  end

  // fatal flags bypass the enables; halted never interrupts; the rest need their enable
  always_comb begin
    irq_nxt = sts_r[`UHS_STS_PROC_ERR] || sts_r[`UHS_STS_SYS_ERR];
    irq_nxt = irq_nxt || (sts_r[`UHS_STS_RESUME] && en_r[`UHS_EN_RESUME]);
    irq_nxt = irq_nxt || (sts_r[`UHS_STS_ERR_INT] && en_r[`UHS_EN_TIMEOUT]);
    irq_nxt = irq_nxt || (sts_r[`UHS_STS_DONE_INT] && done_cause_r && en_r[`UHS_EN_DONE]);
    irq_nxt = irq_nxt || (sts_r[`UHS_STS_DONE_INT] && short_cause_r && en_r[`UHS_EN_SHORT]);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= irq_nxt;
    end
  end

  uhs_frame_timer #(
    .FRAME_CYCLES(FRAME_CYCLES)
  ) u_frame_timer (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .ce(ce),
    .run(state_r == uhs_pkg::UHS_RUNNING),
    .tick(frame_tick)
  );

  // a software write while stopped takes priority over a stray last tick
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_number <= `UHS_RST_FRAME_INDEX;
    end else if (ce) begin
      if (wr_frn) begin
        frame_number <= io_wdata[`UHS_FRN_WIDTH-1:0];
      end else if (frame_tick) begin
        frame_number <= frame_number + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_list_addr <= '0;
    end else if (ce) begin
      frame_list_addr <= {frame_list_base[31:`UHS_BASE_LSB], frame_number[`UHS_FRN_IDX_WIDTH-1:0], 2'b00};
    end
  end

  // reads have no side effects; unmapped offsets read zero
  always_comb begin
    rdata_nxt = '0;
    case (io_addr)
      `UHS_OFS_EVENT_FLAGS: rdata_nxt[`UHS_STS_WIDTH-1:0] = sts_r;
      `UHS_OFS_INT_ENABLES: rdata_nxt[`UHS_EN_WIDTH-1:0] = en_r;
      `UHS_OFS_FRAME_INDEX: rdata_nxt[`UHS_FRN_WIDTH-1:0] = frame_number;
      default: rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      io_rdata <= '0;
    end else if (ce) begin
      io_rdata <= io_rd ? rdata_nxt : 16'h0000;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  a_w1c_clears: assert property (ce && wr_sts && io_be[0] && io_wdata[`UHS_STS_RESUME] && !sts_set[`UHS_STS_RESUME]
    |=> !sts_r[`UHS_STS_RESUME])
    else $error("resume flag survived a write of one");

  a_rsvd_reads_zero: assert property (ce && io_rd && io_addr == `UHS_OFS_EVENT_FLAGS
    |=> io_rdata[15:`UHS_STS_WIDTH] == '0 && io_rdata[`UHS_STS_WIDTH-1:0] == $past(sts_r))
    else $error("status read returned wrong value");

  a_halt_after_drain: assert property (ce && state_r == uhs_pkg::UHS_DRAINING && !run_stop && !xact_busy
    |=> sts_r[`UHS_STS_HALTED] && state_r == uhs_pkg::UHS_STOPPED)
    else $error("halted flag not set after stop");

  a_no_halt_while_busy: assert property (ce && state_r == uhs_pkg::UHS_RUNNING && !run_stop && xact_busy
    |=> state_r == uhs_pkg::UHS_DRAINING)
    else $error("stopped before transaction completed");

  a_proc_err_stop: assert property (ce && consistency_err
    |=> sts_r[`UHS_STS_PROC_ERR] && run_stop_clr)
    else $error("process error not flagged or run not cleared");

  a_sys_err_stop: assert property (ce && sys_err |=> sts_r[`UHS_STS_SYS_ERR] && run_stop_clr)
    else $error("system error not flagged or run not cleared");

  a_resume_gated: assert property (ce && !resume_sync_r |=> $past(sts_r[`UHS_STS_RESUME]) || !sts_r[`UHS_STS_RESUME])
    else $error("resume flag set without resume");

  a_err_and_done: assert property (ce && xact_done && xact_err && xact_notify
    |=> sts_r[`UHS_STS_ERR_INT] && sts_r[`UHS_STS_DONE_INT])
    else $error("error with notify did not set both flags");

  a_short_done: assert property (ce && done_short |=> sts_r[`UHS_STS_DONE_INT] && short_cause_r)
    else $error("short packet did not set completion flag");

  a_fatal_unmasked: assert property (ce && sts_r[`UHS_STS_PROC_ERR] |=> irq)
    else $error("process error did not interrupt");

  a_masked_quiet: assert property (ce && en_r == '0 && sts_r[`UHS_STS_PROC_ERR:`UHS_STS_SYS_ERR] == '0 |=> !irq)
    else $error("interrupt raised with all sources masked");

  a_frame_step: assert property (ce && frame_tick && !wr_frn |=> frame_number == $past(frame_number) + 11'h001)
    else $error("frame counter did not step");

  a_frame_wr_lock: assert property (ce && io_wr && io_addr == `UHS_OFS_FRAME_INDEX && run_stop && !frame_tick
    |=> frame_number == $past(frame_number))
    else $error("frame number written while running");

  // the address flop follows the frame number one cycle behind
  a_list_addr: assert property (ce ##1 ce |=> frame_list_addr[11:0] == {$past(frame_number[9:0]), 2'b00})
    else $error("frame list address does not follow index");

  c_fatal_stop: cover property (ce && consistency_err ##[1:8] state_r == uhs_pkg::UHS_STOPPED);
  c_frame_tick: cover property (frame_tick);
  c_masked_done: cover property (ce && done_notify && !en_r[`UHS_EN_DONE] ##1 !irq);

endmodule

/* sim/uhs_cmd_model.sv */
// command logic model: holds the run control bit seen by the status block
// assumes set_run and clr_run are one-cycle software pulses on core_clk
`timescale 1ns/1ps
module uhs_cmd_model (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic set_run,
  input wire logic clr_run,
  input wire logic run_stop_clr,
  output logic run_stop
);
  // the hardware clear wins, so a fatal error cannot be overridden in the same cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_stop <= 1'b0;
    end else if (run_stop_clr || clr_run) begin
      run_stop <= 1'b0;
    end else if (set_run) begin
      run_stop <= 1'b1;
    end
  end
endmodule

/* sim/testbench.sv */
// self-checking bench for the status, enable and frame number registers
// assumes a shortened frame period; the command model stands in for software
`timescale 1ns/1ps
module testbench;
  localparam int FC = 16;
  logic core_clk = 1'b0, arst_n = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
  logic ce = 1'b1;
  logic [7:0] io_addr = 8'h00;
  logic [1:0] io_be = 2'h0;
  logic [15:0] io_wdata = 16'h0000;
  logic set_run = 1'b0, clr_run = 1'b0, xact_busy = 1'b0, consistency_err = 1'b0;
  logic sys_err = 1'b0, resume_pin = 1'b0, global_suspend = 1'b0, xact_done = 1'b0;
  logic xact_err = 1'b0, xact_notify = 1'b0, short_pkt = 1'b0, short_detect_en = 1'b0;
  logic [31:0] base = 32'h12345abc;
  logic [15:0] io_rdata;
  logic irq, run_stop_clr, run_stop;
  logic [10:0] frame_number;
  logic [31:0] frame_list_addr;
  logic [15:0] exp_flags [4] = '{16'h0002, 16'h0004, 16'h0001, 16'h0001};
  int fails = 0;
  int checked = 0;
  int n;

  always #10 core_clk = ~core_clk;

  uhs_cmd_model u_cmd (.core_clk(core_clk), .arst_n(arst_n), .set_run(set_run), .clr_run(clr_run),
    .run_stop_clr(run_stop_clr), .run_stop(run_stop));

  uhs_status_frame #(.FRAME_CYCLES(FC)) u_dut (.core_clk(core_clk), .arst_n(arst_n), .ce(ce),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_be(io_be), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .run_stop(run_stop), .global_suspend(global_suspend),
    .xact_busy(xact_busy), .consistency_err(consistency_err), .sys_err(sys_err),
    .resume_pin(resume_pin), .xact_done(xact_done), .xact_err(xact_err),
    .xact_notify(xact_notify), .short_pkt(short_pkt), .short_detect_en(short_detect_en),
    .frame_list_base(base), .irq(irq), .run_stop_clr(run_stop_clr),
    .frame_number(frame_number), .frame_list_addr(frame_list_addr));

  task stop_test();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // inputs always move 2 ns after the rising edge
  task cyc(input int c);
    repeat (c) @(posedge core_clk);
    #2;
  endtask

  task chk(input string name, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, e, s);
    end
  endtask

  // the leading idle cycle keeps two strobes from being assigned in one step
  task wr(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
    cyc(1);
    io_addr = a;
    io_be = b;
    io_wdata = d;
    io_wr = 1'b1;
    cyc(1);
    io_wr = 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [15:0] e);
    cyc(1);
    io_addr = a;
    io_rd = 1'b1;
    cyc(1);
    io_rd = 1'b0;
    chk("io_rdata", {16'h0000, e}, {16'h0000, io_rdata});
  endtask

  // 0 error, 1 resume, 2 notify, 3 short packet, 4 plain done, 5 error with notify
  task ev(input int k);
    xact_done = (k != 1);
    xact_err = (k == 0 || k == 5);
    xact_notify = (k == 2 || k == 5);
    short_pkt = (k == 3);
    short_detect_en = (k == 3);
    global_suspend = (k == 1);
    resume_pin = (k == 1);
    cyc(k == 1 ? 4 : 1);
    {xact_done, xact_err, xact_notify, short_pkt, short_detect_en, resume_pin} = 6'h00;
    cyc(1);
    global_suspend = 1'b0;
  endtask

  task wait_fn(output int c);
    logic [10:0] p;
    p = frame_number;
    c = 0;
    while (frame_number === p && c < 100) begin
      cyc(1);
      c++;
    end
    if (c >= 100) begin
      fails++;
      stop_test();
    end
  endtask

  initial begin
    cyc(4);
    arst_n = 1'b1;
    rd(8'h02, 16'h0020);
    rd(8'h04, 16'h0000);
    rd(8'h06, 16'h0000);
    wr(8'h02, 2'h3, 16'h0000);
    rd(8'h02, 16'h0020);
    wr(8'h02, 2'h3, 16'hffff);
    rd(8'h02, 16'h0000);
    wr(8'h04, 2'h3, 16'hffff);
    rd(8'h04, 16'h000f);
    wr(8'h08, 2'h3, 16'hffff);
    rd(8'h08, 16'h0000);
    wr(8'h06, 2'h1, 16'h0155);
    rd(8'h06, 16'h0000);
    wr(8'h06, 2'h3, 16'hfffe);
    rd(8'h06, 16'h07fe);
    chk("frame_list_addr", {base[31:12], 10'h3fe, 2'h0}, frame_list_addr);
    resume_pin = 1'b1;
    cyc(5);
    resume_pin = 1'b0;
    cyc(3);
    rd(8'h02, 16'h0000);
    set_run = 1'b1;
    cyc(1);
    set_run = 1'b0;
    wait_fn(n);
    chk("frame_number", 32'h7ff, frame_number);
    wr(8'h06, 2'h3, 16'h0123);
    wait_fn(n);
    chk("frame_number", 32'h000, frame_number);
    wait_fn(n);
    chk("frame_period", FC, n);
    cyc(1);
    chk("frame_list_addr", {base[31:12], 10'h001, 2'h0}, frame_list_addr);
    wr(8'h04, 2'h3, 16'h0000);
    xact_busy = 1'b1;
    consistency_err = 1'b1;
    cyc(1);
    consistency_err = 1'b0;
    chk("run_stop_clr", 1, run_stop_clr);
    cyc(1);
    chk("irq", 1, irq);
    rd(8'h02, 16'h0010);
    xact_busy = 1'b0;
    cyc(2);
    rd(8'h02, 16'h0030);
    wr(8'h02, 2'h3, 16'h0030);
    cyc(2);
    chk("irq", 0, irq);
    set_run = 1'b1;
    cyc(2);
    set_run = 1'b0;
    sys_err = 1'b1;
    cyc(1);
    sys_err = 1'b0;
    chk("run_stop_clr", 1, run_stop_clr);
    cyc(1);
    chk("irq", 1, irq);
    rd(8'h02, 16'h0028);
    wr(8'h02, 2'h3, 16'h003f);
    for (int k = 0; k < 4; k++) begin
      ev(k);
      cyc(2);
      rd(8'h02, exp_flags[k]);
      chk("irq", 0, irq);
      wr(8'h04, 2'h3, 16'h0001 << k);
      cyc(2);
      chk("irq", 1, irq);
      wr(8'h02, 2'h3, 16'h003f);
      cyc(2);
      chk("irq", 0, irq);
      wr(8'h04, 2'h3, 16'h0000);
    end
    ev(5);
    cyc(2);
    rd(8'h02, 16'h0003);
    wr(8'h02, 2'h2, 16'h0003);
    rd(8'h02, 16'h0003);
    wr(8'h02, 2'h3, 16'h0003);
    ev(4);
    cyc(2);
    rd(8'h02, 16'h0000);
    wr(8'h06, 2'h3, 16'h0400);
    rd(8'h06, 16'h0400);
    // second reset while stopped: flags, frame and enables return to their reset values
    arst_n = 1'b0;
    cyc(2);
    arst_n = 1'b1;
    rd(8'h02, 16'h0020);
    rd(8'h06, 16'h0000);
    // a write offered while the clock enable is low must not land
    ce = 1'b0;
    wr(8'h04, 2'h3, 16'h000f);
    ce = 1'b1;
    rd(8'h04, 16'h0000);
    stop_test();
  end
endmodule
